// file: src/prf_crc8.sv
// Bit-serial CRC-8 accumulator for the response frame
`timescale 1ns/1ns
module prf_crc8 (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic init_in,
  input wire logic shift_in,
  input wire logic bit_in,
  output logic [7:0] crc_out
);
  logic [7:0] crc_ff; // Running remainder
  logic fb; // Feedback bit
  assign fb = crc_ff[7] ^ bit_in;
  assign crc_out = crc_ff;
  // Seed on frame start, shift one bit per data cycle
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      crc_ff <= prf_pkg::CRC_SEED;
    end else if (init_in) begin
      crc_ff <= prf_pkg::CRC_SEED;
    end else if (shift_in) begin
      crc_ff <= {crc_ff[6:0], 1'b0} ^ (fb ? prf_pkg::CRC_POLY : 8'h00);
    end
  end
endmodule : prf_crc8

// file: src/prf_framer.sv
// Periodic data collection response framer, serial bit output
//
// Operation
// - Same symbol stream as command replies
// - Order: id, counter, status, data, CRC
// - Id field carries configured source identifier
// - Two-bit counter per source, starts 00
// - Data field chosen by data type select
// - Frame ends with eight-bit CRC
// - Status field four bits or absent
// - Normal mode sends zero status, real data
// - Reply to broadcast read or fragment
// - Respond only after init done flag set
`timescale 1ns/1ns
module prf_framer #(
  parameter int NUM_SRC = 2,
  parameter int DATA_W = 16
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic init_done_flag_in,
  input wire logic trigger_in,
  input wire logic [$clog2(NUM_SRC)-1:0] src_sel_in,
  input wire prf_pkg::prf_src_cfg_t [NUM_SRC-1:0] source_config_reg_in,
  input wire logic [4*DATA_W-1:0] sensor_data_in,
  input wire logic normal_mode_in,
  input wire logic [3:0] error_code_in,
  output prf_pkg::prf_sym_t sym_out,
  output logic busy_out,
  output logic [2*NUM_SRC-1:0] keep_alive_counter_out
);
  localparam int SH_W = 4 + 2 + 4 + DATA_W;
  localparam int CNT_W = $clog2(SH_W + 1);
  localparam int SW = $clog2(NUM_SRC);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum {PRF_IDLE, PRF_BODY, PRF_CRC} prf_state_t;
  prf_state_t state_ff; // Frame sequencer state
  logic [SH_W-1:0] shift_ff; // Body bits, MSB first
  logic [CNT_W-1:0] left_ff; // Body bits still to send
  logic [3:0] crc_left_ff; // CRC bits still to send
  logic [7:0] crc_sh_ff; // Captured CRC being shifted out
  logic [SW-1:0] src_ff; // Source of the frame in flight
  logic [1:0] kac_ff [NUM_SRC]; // Keep-alive counters
  logic first_ff; // Marks first bit of frame
  logic [7:0] crc_val; // CRC accumulator value
  logic crc_init;
  logic crc_shift;
  prf_pkg::prf_sym_t sym_ff; // Registered output symbol
  // Selects a data word by type code
  function automatic logic [DATA_W-1:0] pick_data(
    input logic [4*DATA_W-1:0] d, input logic [1:0] t);
    pick_data = d[t*DATA_W +: DATA_W];
  endfunction : pick_data
  ////////////////////////////////////////////////////////////////////////////
  // Assemble body and width for the chosen source
  prf_pkg::prf_src_cfg_t cfg;
  logic [SH_W-1:0] body;
  logic [CNT_W-1:0] blen;
  always_comb begin
    cfg = source_config_reg_in[src_sel_in];
    body = '0;
    blen = '0;
    // Source identifier first
    if (cfg.response_format_select[prf_pkg::FMT_SRC_BIT]) begin
      body = {body[SH_W-5:0], cfg.source_identifier};
      blen = blen + CNT_W'(4);
    end
    if (cfg.response_format_select[prf_pkg::FMT_KAC_BIT]) begin
      body = {body[SH_W-3:0], kac_ff[src_sel_in]};
      blen = blen + CNT_W'(2);
    end
    // Status: zero in normal mode, else the error code
    if (cfg.response_format_select[prf_pkg::FMT_STAT_BIT]) begin
      body = {body[SH_W-5:0],
              normal_mode_in ? prf_pkg::STAT_NORMAL : error_code_in};
      blen = blen + CNT_W'(4);
    end
    body = {body[SH_W-DATA_W-1:0],
            pick_data(sensor_data_in, cfg.data_type_select)};
    blen = blen + CNT_W'(DATA_W);
    // Left-align so the first field leaves first
    body = body << (CNT_W'(SH_W) - blen);
  end
  ////////////////////////////////////////////////////////////////////////////
  // Start only when enabled and idle; trigger mid-frame is ignored
  logic start;
  assign start = (state_ff == PRF_IDLE) && trigger_in
                 && init_done_flag_in;
  assign crc_init = start;
  assign crc_shift = (state_ff == PRF_BODY);
  prf_crc8 u_crc (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .init_in(crc_init),
    .shift_in(crc_shift),
    .bit_in(shift_ff[SH_W-1]),
    .crc_out(crc_val)
  );
  // Sequencer
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state_ff <= PRF_IDLE;
      shift_ff <= '0;
      left_ff <= '0;
      crc_left_ff <= 4'h0;
      crc_sh_ff <= 8'h00;
      src_ff <= '0;
      first_ff <= 1'b0;
    end else begin
      case (state_ff)
        PRF_IDLE: begin
          if (start) begin
            state_ff <= PRF_BODY;
            shift_ff <= body;
            left_ff <= blen;
            src_ff <= src_sel_in;
            first_ff <= 1'b1;
          end
        end
        PRF_BODY: begin
          shift_ff <= shift_ff << 1;
          left_ff <= left_ff - CNT_W'(1);
          first_ff <= 1'b0;
          if (left_ff == CNT_W'(1)) begin
            state_ff <= PRF_CRC;
            crc_left_ff <= 4'h8;
          end
        end
        PRF_CRC: begin
          if (crc_left_ff == 4'h8) begin
            crc_sh_ff <= {crc_val[6:0], 1'b0};
          end else begin
            crc_sh_ff <= crc_sh_ff << 1;
          end
          crc_left_ff <= crc_left_ff - 4'h1;
          if (crc_left_ff == 4'h1) begin
            state_ff <= PRF_IDLE;
          end
        end
        default: state_ff <= PRF_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Output bit stream; encoding left to the shared symbol encoder
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      sym_ff <= '0;
    end else begin
      sym_ff.valid <= (state_ff != PRF_IDLE);
      sym_ff.first <= (state_ff == PRF_BODY) && first_ff;
      sym_ff.last <= (state_ff == PRF_CRC) && (crc_left_ff == 4'h1);
      if (state_ff == PRF_BODY) begin
        sym_ff.bit_val <= shift_ff[SH_W-1];
      end else if (state_ff == PRF_CRC) begin
        sym_ff.bit_val <= (crc_left_ff == 4'h8) ? crc_val[7] : crc_sh_ff[7];
      end else begin
        sym_ff.bit_val <= 1'b0;
      end
    end
  end
  assign sym_out = sym_ff;
  // Busy flag
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= start || ((state_ff != PRF_IDLE)
                  && !((state_ff == PRF_CRC) && (crc_left_ff == 4'h1)));
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Keep-alive counters, one per source, bumped at frame end
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_kac
      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          kac_ff[g] <= prf_pkg::KAC_INIT;
        end else if ((state_ff == PRF_CRC) && (crc_left_ff == 4'h1)
                     && (src_ff == SW'(g))) begin
          kac_ff[g] <= kac_ff[g] + 2'h1;
        end
      end
      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          keep_alive_counter_out[2*g +: 2] <= prf_pkg::KAC_INIT;
        end else begin
          keep_alive_counter_out[2*g +: 2] <= kac_ff[g];
        end
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // No frame may start while initialisation is unfinished
  no_start_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (!init_done_flag_in && state_ff == PRF_IDLE) |=> state_ff == PRF_IDLE)
    else $error("frame started before init done");
  // Trigger while enabled brings first output bit two cycles later
  trig_reply_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    start |-> ##2 (sym_out.valid && sym_out.first))
    else $error("no reply to trigger");
  // After body, exactly eight CRC bits then last
  crc_len_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (state_ff == PRF_BODY && left_ff == CNT_W'(1)) |=> ##7
    (state_ff == PRF_CRC && crc_left_ff == 4'h1))
    else $error("crc field not eight bits");
  // Counter advances by one at frame end
  kac_step_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (state_ff == PRF_CRC && crc_left_ff == 4'h1) |=>
    kac_ff[src_ff] == $past(kac_ff[src_ff]) + 2'h1)
    else $error("keep alive counter step wrong");
  // Last CRC bit is flagged and busy drops with it; a stuck busy would
  // hold off the next broadcast read
  frame_end_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (state_ff == PRF_CRC && crc_left_ff == 4'h1) |=>
    (sym_out.valid && sym_out.last && !busy_out))
    else $error("frame end not flagged");
  // A trigger mid-body must not reload the frame: the master may repeat
  // reads while a reply is still on the wire
  no_restart_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (state_ff == PRF_BODY && trigger_in) |=>
    left_ff == $past(left_ff) - CNT_W'(1))
    else $error("trigger restarted a frame");
endmodule : prf_framer

// file: src/prf_pkg.sv
// Package for the periodic response framer: constants and carrier types
package prf_pkg;
  // Field widths of the response frame and of the configuration word
  localparam int SRC_ID_W = 4;
  localparam int KAC_W = 2;
  localparam int STAT_W = 4;
  localparam int CRC_W = 8;
  localparam int FMT_W = 3;
  localparam int DTYPE_W = 2;
  // Format select bit positions: source id, counter, status enables
  localparam int FMT_SRC_BIT = 0;
  localparam int FMT_KAC_BIT = 1;
  localparam int FMT_STAT_BIT = 2;
  // Status code sent in normal operation, all four bits zero
  localparam logic [3:0] STAT_NORMAL = 4'h0;
  // Counter reset value
  localparam logic [1:0] KAC_INIT = 2'h0;
  // CRC seed and polynomial (plain defaults)
  localparam logic [7:0] CRC_SEED = 8'hFF;
  localparam logic [7:0] CRC_POLY = 8'h2F;
  // Per-source configuration carried in one word
  typedef struct packed {
    logic [FMT_W-1:0] response_format_select;
    logic [SRC_ID_W-1:0] source_identifier;
    logic [DTYPE_W-1:0] data_type_select;
  } prf_src_cfg_t;
  // Serial output symbol stream: one bit with valid and frame markers
  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic bit_val;
  } prf_sym_t;
endpackage : prf_pkg

// file: testbench/prf_framer_test.sv
// Self-checking bench for the periodic response framer
`timescale 1ns/1ns
module prf_framer_test;
  logic clk_sys_in = 1'b0; // 50 MHz clock
  logic rstn_in = 1'b0; // Held low six cycles
  logic init_done_flag_in = 1'b0;
  logic req = 1'b0; // Read request to the master model
  logic [0:0] src_sel_in = 1'h0;
  prf_pkg::prf_src_cfg_t [1:0] cfg = '0;
  prf_pkg::prf_src_cfg_t c; // Selected source, model side
  logic [63:0] sensor_data_in = 64'h0;
  logic normal_mode_in = 1'b1;
  logic [3:0] error_code_in = 4'h0;
  prf_pkg::prf_sym_t sym_out;
  logic busy_out, trigger, done;
  logic [3:0] kac_out;
  logic [63:0] frame, exp_bits;
  logic [7:0] len, exp_len, crc;
  logic [31:0] rnd = 32'h3F50;
  int kac_m [2] = '{0, 0}; // Model counters per source
  int bad_count = 0;
  int n_tests = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  prf_framer prf_framer_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .init_done_flag_in(init_done_flag_in), .trigger_in(trigger),
    .src_sel_in(src_sel_in), .source_config_reg_in(cfg),
    .sensor_data_in(sensor_data_in), .normal_mode_in(normal_mode_in),
    .error_code_in(error_code_in), .sym_out(sym_out),
    .busy_out(busy_out), .keep_alive_counter_out(kac_out));
  prf_master prf_master_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .req_in(req), .sym_in(sym_out), .trigger_out(trigger),
    .frame_out(frame), .len_out(len), .done_out(done));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_tests++;
    if (seen !== want) begin
      bad_count++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  // Appends w bits MSB first to the model frame and its running CRC
  task automatic add(input logic [15:0] v, input int w);
    for (int b = w - 1; b >= 0; b--) begin
      exp_bits = {exp_bits[62:0], v[b]};
      exp_len++;
      crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ v[b]) ? prf_pkg::CRC_POLY : 8'h00);
    end
  endtask : add
  // One read; with extra set, one re-request at loop step 5 while busy, which must be ignored
  task automatic run(input bit reply, input bit extra);
    int k;
    @(posedge clk_sys_in) req <= 1'b1;
    for (k = 0; k < 120 && done !== 1'b1; k++) begin
      @(posedge clk_sys_in) req <= extra && k == 5;
      @(negedge clk_sys_in);
      // Busy only when the read was taken
      if (k == 3) check(busy_out, 64'(reply));
    end
    if (reply && k == 120) begin
      bad_count++;
      finish_test();
    end
  endtask : run
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(negedge clk_sys_in);
    check({sym_out, busy_out, kac_out}, 64'h0);
    // Without the init flag a read gets no reply
    run(1'b0, 1'b0);
    check({done, len}, 64'h0);
    @(posedge clk_sys_in) init_done_flag_in <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk_sys_in);
      cfg <= rnd[17:0];
      src_sel_in <= rnd[18];
      normal_mode_in <= rnd[19];
      error_code_in <= rnd[23:20];
      sensor_data_in <= {rnd, lfsr(rnd)};
      @(negedge clk_sys_in);
      c = cfg[src_sel_in];
      exp_bits = 64'h0;
      exp_len = 8'h00;
      crc = prf_pkg::CRC_SEED;
      if (c.response_format_select[0])
        add({12'h0, c.source_identifier}, 4);
      if (c.response_format_select[1]) add(16'(kac_m[src_sel_in]), 2);
      if (c.response_format_select[2])
        add(normal_mode_in ? 16'h0 : {12'h0, error_code_in}, 4);
      add(sensor_data_in[16*c.data_type_select +: 16], 16);
      add({8'h00, crc}, 8);
      run(1'b1, i[0]);
      check(frame, exp_bits);
      check(len, exp_len);
      kac_m[src_sel_in] = (kac_m[src_sel_in] + 1) % 4;
      repeat (2) @(negedge clk_sys_in);
      check({busy_out, sym_out.valid}, 64'h0);
      check(kac_out, {kac_m[1][1:0], kac_m[0][1:0]});
    end
    finish_test();
  end
endmodule : prf_framer_test

// file: testbench/prf_master.sv
// Bus master model: issues broadcast reads and gathers reply bits
`timescale 1ns/1ns
module prf_master (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic req_in,
  input wire prf_pkg::prf_sym_t sym_in,
  output logic trigger_out,
  output logic [63:0] frame_out,
  output logic [7:0] len_out,
  output logic done_out
);
  // One-cycle read per request; reply bits shift in, first bit restarts
  always_ff @(posedge clk_sys_in) begin
    trigger_out <= rstn_in && req_in;
    done_out <= rstn_in && sym_in.valid && sym_in.last;
    if (!rstn_in || (sym_in.valid && sym_in.first)) begin
      frame_out <= {63'h0, sym_in.valid & sym_in.bit_val};
      len_out <= {7'h0, sym_in.valid};
    end else if (sym_in.valid) begin
      frame_out <= {frame_out[62:0], sym_in.bit_val};
      len_out <= len_out + 8'h01;
    end
  end
endmodule : prf_master
